// ==== rtl/pfsw_pkg.sv ====
package pfsw_pkg;

    // ========================================
    // register byte offsets
    localparam logic [7:0] OFF_ADDR_LO = 8'h00;
    localparam logic [7:0] OFF_ADDR_HI = 8'h04;
    localparam logic [7:0] OFF_DATA_LO = 8'h08;
    localparam logic [7:0] OFF_DATA_HI = 8'h0c;
    localparam logic [7:0] OFF_CTRL = 8'h10;
    localparam logic [7:0] OFF_UNLOCK = 8'h14;
    localparam logic [7:0] OFF_CFG = 8'h18;

    // ========================================
    // nv_control field positions
    localparam int CTL_PGM = 7;
    localparam int CTL_ERR = 3;
    localparam int CTL_ARM = 2;
    localparam int CTL_GO = 1;

    // ========================================
    // unlock keys and timing
    localparam logic [7:0] UNLOCK_A = 8'h55;
    localparam logic [7:0] UNLOCK_B = 8'haa;
    localparam int CLK_HZ = 10_000_000;
    localparam int PWRT_MS = 72;
    localparam int PWRT_CYC = PWRT_MS * (CLK_HZ / 1000);
    localparam logic [1:0] STALL_CYC = 2'h2;
    localparam int PROG_AW = 11;
    localparam logic [PROG_AW-1:0] PROT_BASE_DEF = 11'h400;

    // ========================================
    // carriers
    typedef struct packed {
        logic data_unprot;   // 1 = data eeprom not protected
        logic permit;        // self_write_permit
        logic cp_hi;         // code_protect_hi
        logic cp_lo;         // code_protect_lo
    } pfsw_cfg_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [13:0] data;
    } pfsw_freq_t;

    typedef enum logic [1:0] {UL_IDLE, UL_55, UL_AA} pfsw_unl_t;

    typedef struct packed {
        pfsw_cfg_t sync1;
        pfsw_cfg_t sync2;
        logic [7:0] addr_lo;
        logic [7:0] addr_hi;
        logic [7:0] data_lo;
        logic [5:0] data_hi;
        logic pgm;
        logic err;
        logic arm;
        logic go;
        logic ee_busy;
        pfsw_unl_t unl;
        logic [1:0] stall;
        logic busy;
        logic [19:0] pwrt;
        logic pwrt_done;
        logic ph_v;
        logic ph_w;
        logic [7:0] ph_a;
        logic [31:0] rdata;
        logic rdy;
        logic fl_wr;
        logic ee_wr;
        logic ext_rd;
        logic ext_wr;
    } pfsw_state_t;

    localparam pfsw_state_t ST_RST = '{rdy: 1'b1, unl: UL_IDLE, default: '0};

endpackage

// ==== rtl/pfsw_top.sv ====
// ========================================
// Summary of operation
// - no or full protect: write needs permit
// - partial protect: unprotected word and permit
// - start needs 55h then AAh unlock
// - core stalls two cycles during write
// - two following instructions are not executed
// - execution resumes at third instruction
// - power-up clears write enable arm
// - power-up timer blocks data writes
// - permit zero refuses all program self writes; data eeprom writes ignore permit
// - configuration bits not writable by firmware
// - any protection disables external writes; partial protect still allows external reads of unprotected words, here only with data_unprot set
// - core data access ignores data protect
// - core program reads ignore protect bits
// - config bits erase only by full erase
// - external access matrix per protect bits
// - unlock plus arm guard data writes
// - start needs arm set by earlier write
`timescale 1ns/100ps
`default_nettype none

module pfsw_top #(
    parameter int PWRT_CYCLES = pfsw_pkg::PWRT_CYC,
    parameter logic [pfsw_pkg::PROG_AW-1:0] PROT_BASE = pfsw_pkg::PROT_BASE_DEF
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // configuration fuses, external pins
    input wire pfsw_pkg::pfsw_cfg_t cfg_i,
    // nonvolatile arrays
    input wire logic ee_done_i,
    output logic fl_wr_o,
    output pfsw_pkg::pfsw_freq_t fl_req_o,
    output logic ee_wr_o,
    output logic cpu_stall_o,
    // external programmer access
    input wire logic [pfsw_pkg::PROG_AW-1:0] ext_addr_i,
    output logic ext_rd_ok_o,
    output logic ext_wr_ok_o
);

    // ========================================
    // elaboration checks
    if (PWRT_CYCLES < 1 || PWRT_CYCLES > 1048575) begin : g_bad_pwrt
        $error("PWRT_CYCLES out of range");
    end

    pfsw_pkg::pfsw_state_t q;
    pfsw_pkg::pfsw_state_t n;

    // word lies in the protected segment for the current protect setting
    function automatic logic is_prot(input pfsw_pkg::pfsw_cfg_t c, input logic [pfsw_pkg::PROG_AW-1:0] a);
        if (c.cp_hi && c.cp_lo) begin
            is_prot = 1'b0;
        end else if (!c.cp_hi && !c.cp_lo) begin
            is_prot = 1'b1;
        end else begin
            is_prot = (a >= PROT_BASE);
        end
    endfunction

    // self write allowed for this word; internal reads never consult this
    function automatic logic self_ok(input pfsw_pkg::pfsw_cfg_t c, input logic [pfsw_pkg::PROG_AW-1:0] a);
        logic partial;
        partial = c.cp_hi ^ c.cp_lo;
        self_ok = c.permit && (!partial || !is_prot(c, a));
    endfunction

    // read mux on the post-write state so a read right after a write sees it
    function automatic logic [31:0] rd_mux(input pfsw_pkg::pfsw_state_t s, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0;
        unique case (a)
            pfsw_pkg::OFF_ADDR_LO: r[7:0] = s.addr_lo;
            pfsw_pkg::OFF_ADDR_HI: r[7:0] = s.addr_hi;
            pfsw_pkg::OFF_DATA_LO: r[7:0] = s.data_lo;
            pfsw_pkg::OFF_DATA_HI: r[5:0] = s.data_hi;
            pfsw_pkg::OFF_CTRL: begin
                r[pfsw_pkg::CTL_PGM] = s.pgm;
                r[pfsw_pkg::CTL_ERR] = s.err;
                r[pfsw_pkg::CTL_ARM] = s.arm;
                r[pfsw_pkg::CTL_GO] = s.go;
            end
            pfsw_pkg::OFF_CFG: r[4:0] = {s.sync2, s.pwrt_done};
            default: r = 32'h0; // unlock reads zero, unmapped reads zero
        endcase
        return r;
    endfunction

    logic [pfsw_pkg::PROG_AW-1:0] cur_addr;
    logic [31:0] wd;
    assign cur_addr = {q.addr_hi[pfsw_pkg::PROG_AW-9:0], q.addr_lo};
    assign wd = hwdata_i;

    // ========================================
    // next state
    always_comb begin
        n = q;
        n.fl_wr = 1'b0;
        n.ee_wr = 1'b0;
        // power-up timer
        if (!q.pwrt_done) begin
            n.pwrt = q.pwrt + 20'h1;
            n.pwrt_done = (q.pwrt == 20'(PWRT_CYCLES - 1));
        end
        // program write stall countdown, start bit drops as the core resumes
        if (q.stall != 2'h0) begin
            n.stall = q.stall - 2'h1;
            if (q.stall == 2'h1) begin
                n.go = 1'b0;
            end
        end
        // data eeprom completion
        if (q.ee_busy && ee_done_i) begin
            n.go = 1'b0;
            n.ee_busy = 1'b0;
        end
        // data phase write, held off while the core is stalled
        if (q.ph_v && q.ph_w && q.rdy) begin
            n.unl = pfsw_pkg::UL_IDLE; // any other write breaks the unlock sequence
            unique case (q.ph_a)
                pfsw_pkg::OFF_ADDR_LO: n.addr_lo = wd[7:0];
                pfsw_pkg::OFF_ADDR_HI: n.addr_hi = wd[7:0];
                pfsw_pkg::OFF_DATA_LO: n.data_lo = wd[7:0];
                pfsw_pkg::OFF_DATA_HI: n.data_hi = wd[5:0];
                pfsw_pkg::OFF_UNLOCK: begin
                    if (wd[7:0] == pfsw_pkg::UNLOCK_A) begin
                        n.unl = pfsw_pkg::UL_55;
                    end else if (q.unl == pfsw_pkg::UL_55 && wd[7:0] == pfsw_pkg::UNLOCK_B) begin
                        n.unl = pfsw_pkg::UL_AA;
                    end
                end
                pfsw_pkg::OFF_CTRL: begin
                    n.pgm = q.go ? q.pgm : wd[pfsw_pkg::CTL_PGM];
                    n.err = wd[pfsw_pkg::CTL_ERR]; // software writes the value, a refusal below still wins
                    n.arm = wd[pfsw_pkg::CTL_ARM]; // clearing arm mid-write leaves it running
                    // arm must already be set and the unlock complete
                    if (wd[pfsw_pkg::CTL_GO] && !q.go && q.arm && q.unl == pfsw_pkg::UL_AA) begin
                        if (n.pgm) begin
                            if (self_ok(q.sync2, cur_addr)) begin
                                n.go = 1'b1;
                                n.fl_wr = 1'b1;
                                n.stall = pfsw_pkg::STALL_CYC;
                            end else begin
                                n.err = 1'b1;
                            end
                        end else if (q.pwrt_done) begin
                            n.go = 1'b1;
                            n.ee_busy = 1'b1;
                            n.ee_wr = 1'b1;
                        end else begin
                            n.err = 1'b1;
                        end
                    end
                end
                default: ;
            endcase
        end
        // core stall holds the bus so the next instructions wait
        n.busy = (n.stall != 2'h0);
        n.rdy = (n.stall == 2'h0);
        // address phase capture
        if (hready_i) begin
            n.ph_v = hsel_i && htrans_i[1];
            n.ph_w = hwrite_i;
            n.ph_a = haddr_i[7:0];
            if (hsel_i && htrans_i[1] && !hwrite_i) begin
                n.rdata = rd_mux(n, haddr_i[7:0]);
            end
        end
        // fuse synchroniser, stepped after the read capture so the mux only ever sees the second stage
        n.sync1 = cfg_i; // fuses are read only, only a full erase outside changes them
        n.sync2 = q.sync1;
        // external programmer gating
        n.ext_rd = q.sync2.data_unprot && !is_prot(q.sync2, ext_addr_i);
        n.ext_wr = q.sync2.data_unprot && q.sync2.cp_hi && q.sync2.cp_lo;
    end

    // ========================================
    // state register; reset drops arm and start
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            q <= pfsw_pkg::ST_RST;
        end else begin
            q <= n;
        end
    end

    // ========================================
    // outputs, all straight from flops except the constant hresp_o
    assign hreadyout_o = q.rdy;
    assign hresp_o = 1'b0; // always okay; hsize_i unused, word access only
    assign hrdata_o = q.rdata;
    assign fl_wr_o = q.fl_wr;
    assign fl_req_o = '{addr: {q.addr_hi, q.addr_lo}, data: {q.data_hi, q.data_lo}};
    assign ee_wr_o = q.ee_wr;
    assign cpu_stall_o = q.busy;
    assign ext_rd_ok_o = q.ext_rd;
    assign ext_wr_ok_o = q.ext_wr;

    // ========================================
    // assertions
    property p_stall_len;
        @(posedge clk_i) disable iff (srst_i) $rose(q.busy) |-> q.busy[*2] ##1 !q.busy;
    endproperty
    a_stall_len: assert property (p_stall_len) else $error("stall not two cycles");

    property p_go_clear;
        @(posedge clk_i) disable iff (srst_i) q.fl_wr |-> q.go ##2 (!q.go && q.rdy);
    endproperty
    a_go_clear: assert property (p_go_clear) else $error("start bit not cleared");

    property p_permit;
        @(posedge clk_i) disable iff (srst_i) $rose(q.fl_wr) |-> $past(q.sync2.permit);
    endproperty
    a_permit: assert property (p_permit) else $error("write without permit");

    property p_partial;
        @(posedge clk_i) disable iff (srst_i)
            q.fl_wr && (q.sync2.cp_hi ^ q.sync2.cp_lo) |-> !is_prot(q.sync2, cur_addr);
    endproperty
    a_partial: assert property (p_partial) else $error("write to protected word");

    property p_pwrt;
        @(posedge clk_i) disable iff (srst_i) q.ee_wr |-> $past(q.pwrt_done);
    endproperty
    a_pwrt: assert property (p_pwrt) else $error("data write during power-up");

    property p_arm_reset;
        @(posedge clk_i) disable iff (srst_i) $fell(srst_i) |-> !q.arm && !q.go;
    endproperty
    a_arm_reset: assert property (p_arm_reset) else $error("arm set after reset");

    property p_unlock;
        @(posedge clk_i) disable iff (srst_i)
            $rose(q.go) |-> $past(q.unl) == pfsw_pkg::UL_AA && $past(q.arm);
    endproperty
    a_unlock: assert property (p_unlock) else $error("start without unlock");

    property p_ext;
        @(posedge clk_i) disable iff (srst_i)
            q.ext_wr || q.ext_rd |-> $past(q.sync2.data_unprot) && $past(q.sync2.cp_hi | q.sync2.cp_lo);
    endproperty
    a_ext: assert property (p_ext) else $error("external access while protected");

    property p_arm_prog;
        @(posedge clk_i) disable iff (srst_i) $rose(q.fl_wr) |-> $past(q.arm);
    endproperty
    a_arm_prog: assert property (p_arm_prog) else $error("program write without arm");

    property p_ee_guard;
        @(posedge clk_i) disable iff (srst_i) q.ee_wr |-> $past(q.arm) && $past(q.unl) == pfsw_pkg::UL_AA;
    endproperty
    a_ee_guard: assert property (p_ee_guard) else $error("data write without unlock and arm");

    property p_stall_fl;
        @(posedge clk_i) disable iff (srst_i) q.fl_wr |-> q.busy && !q.rdy;
    endproperty
    a_stall_fl: assert property (p_stall_fl) else $error("program write without stall");

    property p_resume;
        @(posedge clk_i) disable iff (srst_i) $fell(q.busy) |-> q.rdy && !q.go;
    endproperty
    a_resume: assert property (p_resume) else $error("core resumed with write pending");

    property p_unlock_break;
        @(posedge clk_i) disable iff (srst_i)
            q.ph_v && q.ph_w && q.rdy && q.ph_a != pfsw_pkg::OFF_UNLOCK |=> q.unl == pfsw_pkg::UL_IDLE;
    endproperty
    a_unlock_break: assert property (p_unlock_break) else $error("unlock survived another write");

    property p_ext_wr_full;
        @(posedge clk_i) disable iff (srst_i) q.ext_wr |-> $past(q.sync2.cp_hi && q.sync2.cp_lo);
    endproperty
    a_ext_wr_full: assert property (p_ext_wr_full) else $error("external write while protected");

    property p_pwrt_hold;
        @(posedge clk_i) disable iff (srst_i) q.pwrt_done |=> q.pwrt_done;
    endproperty
    a_pwrt_hold: assert property (p_pwrt_hold) else $error("power-up timer restarted");

    property p_cfg_ro;
        @(posedge clk_i) disable iff (srst_i) !$past(srst_i) |-> q.sync1 == $past(cfg_i);
    endproperty
    a_cfg_ro: assert property (p_cfg_ro) else $error("fuse copy altered from inside");

endmodule

`default_nettype wire

// ==== dv/pfsw_nv_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// ========================================
// nonvolatile arrays: count writes, keep the last program word
module pfsw_nv_model #(
    parameter int DONE_LAT = 10
) (
    // clock
    input wire logic clk_i,
    // requests from the guard
    input wire logic fl_wr_i,
    input wire pfsw_pkg::pfsw_freq_t fl_req_i,
    input wire logic ee_wr_i,
    // answers
    output logic ee_done_o,
    output int fl_cnt_o,
    output int ee_cnt_o,
    output pfsw_pkg::pfsw_freq_t word_o
);
    int wait_q = 0;

    initial begin
        ee_done_o = 1'b0;
        fl_cnt_o = 0;
        ee_cnt_o = 0;
        word_o = '0;
    end

    // done is a single pulse, slow on purpose, so a guard that does not hold start is seen
    always @(posedge clk_i) begin
        ee_done_o <= (wait_q == 1);
        if (ee_wr_i) begin
            ee_cnt_o <= ee_cnt_o + 1;
            wait_q <= DONE_LAT;
        end else if (wait_q != 0) begin
            wait_q <= wait_q - 1;
        end
        if (fl_wr_i) begin
            fl_cnt_o <= fl_cnt_o + 1;
            word_o <= fl_req_i;
        end
    end
endmodule
`default_nettype wire

// ==== dv/test_program_flash_self_write_guard.sv ====
`timescale 1ns/100ps
`default_nettype none

module test_program_flash_self_write_guard;
    localparam logic [31:0] B_PGM = 32'h1 << pfsw_pkg::CTL_PGM;
    localparam logic [31:0] B_ERR = 32'h1 << pfsw_pkg::CTL_ERR;
    localparam logic [31:0] B_ARM = 32'h1 << pfsw_pkg::CTL_ARM;
    localparam logic [31:0] B_GO = 32'h1 << pfsw_pkg::CTL_GO;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic hready, hresp, ee_done, fl_wr, ee_wr, stall, rd_ok, wr_ok;
    logic [31:0] hrdata;
    logic [31:0] r;
    pfsw_pkg::pfsw_cfg_t cfg = 4'hf;
    pfsw_pkg::pfsw_freq_t fl_req, word;
    logic [10:0] ext_addr = '0;
    int fl_cnt, ee_cnt;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    int stall_n = 0;

    pfsw_top #(.PWRT_CYCLES(60), .PROT_BASE(11'h400)) dut (.clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .cfg_i(cfg),
        .ee_done_i(ee_done), .fl_wr_o(fl_wr), .fl_req_o(fl_req), .ee_wr_o(ee_wr), .cpu_stall_o(stall),
        .ext_addr_i(ext_addr), .ext_rd_ok_o(rd_ok), .ext_wr_ok_o(wr_ok));

    pfsw_nv_model nv (.clk_i(clk_i), .fl_wr_i(fl_wr), .fl_req_i(fl_req), .ee_wr_i(ee_wr),
        .ee_done_o(ee_done), .fl_cnt_o(fl_cnt), .ee_cnt_o(ee_cnt), .word_o(word));

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    // cycle ceiling well above the few hundred cycles the tests need
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (stall === 1'b1) stall_n <= stall_n + 1;
        if (cyc == 6000) begin
            fails = fails + 1;
            tally_and_finish;
        end
    end

    // ========================================
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one single transfer; waits on hready, no fixed latency assumed
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_i); while (hready !== 1'b1);
        r = hrdata;
    endtask

    // the go write always sets arm too, so arm only counts when c already holds it
    task automatic start(input logic [31:0] c, input logic [7:0] k1, input logic [7:0] k2);
        bus(1'b1, pfsw_pkg::OFF_CTRL, c);
        bus(1'b1, pfsw_pkg::OFF_UNLOCK, {24'h0, k1});
        bus(1'b1, pfsw_pkg::OFF_UNLOCK, {24'h0, k2});
        bus(1'b1, pfsw_pkg::OFF_CTRL, c | B_GO | B_ARM);
        repeat (4) @(posedge clk_i);
        bus(1'b0, pfsw_pkg::OFF_CTRL, 32'h0);
    endtask

    task automatic load(input logic [15:0] a, input logic [13:0] d);
        bus(1'b1, pfsw_pkg::OFF_ADDR_LO, {24'h0, a[7:0]});
        bus(1'b1, pfsw_pkg::OFF_ADDR_HI, {24'h0, a[15:8]});
        bus(1'b1, pfsw_pkg::OFF_DATA_LO, {24'h0, d[7:0]});
        bus(1'b1, pfsw_pkg::OFF_DATA_HI, {26'h0, d[13:8]});
    endtask

    // ========================================
    // scenarios
    task automatic sc_reset;
        bus(1'b0, pfsw_pkg::OFF_CTRL, 32'h0);
        chk(r, 32'h0);
        chk(hresp, 1'b0);
        bus(1'b0, pfsw_pkg::OFF_CFG, 32'h0);
        chk(r, 32'h1e);
        start(B_ARM, 8'h55, 8'haa);
        chk(r, B_ARM | B_ERR);
        chk(ee_cnt, 0);
    endtask

    task automatic sc_data;
        start(B_ARM, 8'h55, 8'haa);
        chk(r, B_ARM | B_GO);
        chk(ee_cnt, 1);
        repeat (12) @(posedge clk_i);
        bus(1'b0, pfsw_pkg::OFF_CTRL, 32'h0);
        chk(r, B_ARM);
    endtask

    // each row: fuse setting, target word, whether the write may happen
    task automatic sc_prog;
        logic [3:0] cf[5] = '{4'hf, 4'hb, 4'hc, 4'hd, 4'he};
        logic [15:0] ad[5] = '{16'h0123, 16'h0123, 16'h07ff, 16'h03ff, 16'h0400};
        logic ok[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
        int f0, s0;
        for (int i = 0; i < 5; i++) begin
            cfg <= cf[i];
            load(ad[i], 14'h2abc ^ 14'(i));
            f0 = fl_cnt;
            s0 = stall_n;
            start(B_PGM | B_ARM, 8'h55, 8'haa);
            chk(r, B_PGM | B_ARM | (ok[i] ? 32'h0 : B_ERR));
            chk(fl_cnt - f0, ok[i]);
            chk(stall_n - s0, ok[i] ? 2 : 0);
            if (ok[i]) chk(word, {ad[i], 14'h2abc ^ 14'(i)});
        end
    endtask

    task automatic sc_order;
        int f0;
        cfg <= 4'hf;
        f0 = fl_cnt;
        start(B_PGM | B_ARM, 8'haa, 8'h55);
        chk(r, B_PGM | B_ARM);
        start(B_PGM, 8'h55, 8'haa);
        chk(r, B_PGM | B_ARM);
        chk(fl_cnt - f0, 0);
    endtask

    task automatic sc_ext;
        logic pr;
        for (int i = 0; i < 32; i++) begin
            cfg <= i[4:1];
            ext_addr <= i[0] ? 11'h400 : 11'h3ff;
            repeat (4) @(posedge clk_i);
            pr = (i[2] == i[1]) ? !i[1] : i[0];
            chk(rd_ok, i[4] & !pr);
            chk(wr_ok, i[4] & i[2] & i[1]);
        end
        bus(1'b1, pfsw_pkg::OFF_CFG, 32'h0);
        bus(1'b0, pfsw_pkg::OFF_CFG, 32'h0);
        chk(r, 32'h1f);
    endtask

    task automatic tally_and_finish;
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        sc_reset;
        repeat (60) @(posedge clk_i);
        sc_data;
        sc_prog;
        sc_order;
        sc_ext;
        tally_and_finish;
    end
endmodule
`default_nettype wire
